// File: rsmu_consts.vh
// constants for the range select and math unit
`ifndef RSMU_CONSTS_VH
`define RSMU_CONSTS_VH

// measurement function codes
`define RSMU_FN_DCV        4'h0
`define RSMU_FN_ACV        4'h1
`define RSMU_FN_DCI        4'h2
`define RSMU_FN_ACI        4'h3
`define RSMU_FN_RES2W      4'h4
`define RSMU_FN_RES4W      4'h5
`define RSMU_FN_FREQ       4'h6
`define RSMU_FN_PERIOD     4'h7
`define RSMU_FN_CONT       4'h8
`define RSMU_FN_DIODE      4'h9
`define RSMU_FN_RATIO      4'hA
`define RSMU_NUM_FN        11

// math operation codes
`define RSMU_MATH_NULL     3'h0
`define RSMU_MATH_DB       3'h1
`define RSMU_MATH_DBM      3'h2
`define RSMU_MATH_MINMAX   3'h3
`define RSMU_MATH_LIMIT    3'h4
`define RSMU_MATH_COUNT    5

// range indices
`define RSMU_RANGE_LOW     3'h0
`define RSMU_RANGE_TOP     3'h4
`define RSMU_RANGE_CONT    3'h1
`define RSMU_RANGE_DIODE   3'h0

// readings are counts where full scale of the present range is this value
`define RSMU_FULL_SCALE    32'h000F4240
`define RSMU_DOWN_PCT      10
`define RSMU_UP_PCT        120
`define RSMU_DOWN_LIMIT    32'h000186A0
`define RSMU_UP_LIMIT      32'h00124F80

// remote overload word: a single-precision encoding close to 9.9E+37
`define RSMU_OVERLOAD_WORD 32'h7E94F607
// frequency and period report a single 3 Hz range
`define RSMU_FREQ_RANGE_HZ 20'h00003
// diode test source current in mA
`define RSMU_DIODE_SRC_MA  4'h1

// accumulator widths
`define RSMU_SUM_W         48
`define RSMU_CNT_W         16

`endif

// File: rsmu_avg_div.v
// serial divider that forms the min-max average from sum and count
`timescale 1ns/1ps
`default_nettype none
`include "rsmu_consts.vh"

module rsmu_avg_div (
  // clock and reset
  input  wire                   ref_clk,
  input  wire                   rst_n,
  // request
  input  wire                   start,
  input  wire [`RSMU_SUM_W-1:0] sum,
  input  wire [`RSMU_CNT_W-1:0] count,
  // answer
  output reg                    busy,
  output reg                    done,
  output reg  [31:0]            quotient
);

  reg  [`RSMU_SUM_W-1:0] dividend;
  reg  [`RSMU_SUM_W-1:0] quo;
  reg  [`RSMU_CNT_W:0]   rem;
  reg  [`RSMU_CNT_W-1:0] divisor;
  reg  [5:0]             step;
  reg                    neg;
  wire [`RSMU_CNT_W:0]   trial;
  wire [`RSMU_CNT_W:0]   shifted;
  wire [31:0]            q_mag;

  assign shifted = {rem[`RSMU_CNT_W-1:0], dividend[`RSMU_SUM_W-1]};
  // last quotient bit joins the shifted partial quotient
  assign q_mag   = {quo[30:0], ~trial[`RSMU_CNT_W]};
  assign trial   = shifted - {1'b0, divisor};

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy     <= 1'b0;
      done     <= 1'b0;
      quotient <= 32'h00000000;
      dividend <= {`RSMU_SUM_W{1'b0}};
      quo      <= {`RSMU_SUM_W{1'b0}};
      rem      <= {(`RSMU_CNT_W+1){1'b0}};
      divisor  <= {`RSMU_CNT_W{1'b0}};
      step     <= 6'h00;
      neg      <= 1'b0;
    end else begin
      done <= 1'b0;
      // a new start aborts a running division: only the latest sum counts
      if (start) begin
        busy     <= (count != {`RSMU_CNT_W{1'b0}});
        neg      <= sum[`RSMU_SUM_W-1];
        dividend <= sum[`RSMU_SUM_W-1] ? (~sum + 1'b1) : sum;
        divisor  <= count;
        quo      <= {`RSMU_SUM_W{1'b0}};
        rem      <= {(`RSMU_CNT_W+1){1'b0}};
        step     <= 6'h30;
      end else if (busy) begin
        dividend <= {dividend[`RSMU_SUM_W-2:0], 1'b0};
        if (!trial[`RSMU_CNT_W]) begin
          rem <= trial;
          quo <= {quo[`RSMU_SUM_W-2:0], 1'b1};
        end else begin
          rem <= shifted;
          quo <= {quo[`RSMU_SUM_W-2:0], 1'b0};
        end
        step <= step - 6'h01;
        if (step == 6'h01) begin
          busy     <= 1'b0;
          done     <= 1'b1;
          quotient <= neg ? (~q_mag + 32'h00000001) : q_mag;
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: rsmu_top.v
// range selection, overload report, math selection and min-max accumulator
`timescale 1ns/1ps
`default_nettype none
`include "rsmu_consts.vh"

module rsmu_top (
  // clock and reset
  input  wire                   ref_clk,
  input  wire                   rst_n,
  input  wire                   remote_reset,
  // function and range commands
  input  wire                   cmd_function,
  input  wire [3:0]             function_code,
  input  wire                   cmd_range_auto,
  input  wire                   range_auto_on,
  input  wire                   cmd_range_manual,
  input  wire [2:0]             range_value,
  // math commands
  input  wire                   cmd_math_func,
  input  wire [2:0]             math_func_code,
  input  wire                   cmd_math_state,
  input  wire                   math_state_on,
  // readings
  input  wire                   reading_valid,
  input  wire signed [31:0]     reading,
  input  wire                   signal_present,
  input  wire                   menu_open,
  input  wire                   beeper_enable,
  // range status
  output reg  [3:0]             active_function,
  output reg  [2:0]             active_range,
  output reg                    autorange_active,
  output wire                   reference_autorange,
  output wire                   range_is_freq,
  output wire [19:0]            freq_range_hz,
  output wire [3:0]             diode_source_ma,
  // result
  output reg                    result_valid,
  output reg  signed [31:0]     result,
  output reg                    overload_indication,
  output reg  [31:0]            remote_word_is_overload,
  // math status
  output reg  [2:0]             math_func,
  output reg                    math_active,
  output reg                    settings_conflict,
  // min-max results
  output reg  signed [31:0]     minmax_min,
  output reg  signed [31:0]     minmax_max,
  output wire signed [31:0]     minmax_avg,
  output reg  [`RSMU_CNT_W-1:0] minmax_count,
  output wire                   minmax_avg_busy,
  output reg                    new_min,
  output reg                    new_max,
  output reg                    beep
);

  // ----------------------------------------------------------------
  // function decode
  // ----------------------------------------------------------------
  wire clr_all = remote_reset;
  wire is_freq = (active_function == `RSMU_FN_FREQ) ||
                 (active_function == `RSMU_FN_PERIOD);
  wire is_cont = (active_function == `RSMU_FN_CONT);
  wire is_diode = (active_function == `RSMU_FN_DIODE);
  wire fixed_range = is_freq || is_cont || is_diode;

  assign range_is_freq       = is_freq;
  assign freq_range_hz       = is_freq ? `RSMU_FREQ_RANGE_HZ : 20'h00000;
  assign diode_source_ma     = is_diode ? `RSMU_DIODE_SRC_MA : 4'h0;
  assign reference_autorange = (active_function == `RSMU_FN_RATIO);

  // ----------------------------------------------------------------
  // per-function range storage
  // ----------------------------------------------------------------
  wire [`RSMU_NUM_FN-1:0] fn_auto;
  wire [3*`RSMU_NUM_FN-1:0] fn_range;
  wire [31:0] mag = reading[31] ? (~reading + 32'h00000001) : reading;
  wire accept = reading_valid && !menu_open;
  wire too_low  = (mag < `RSMU_DOWN_LIMIT);
  wire too_high = (mag > `RSMU_UP_LIMIT);
  wire [2:0] cur_range = fn_range[3*active_function +: 3];
  wire cur_auto = fn_auto[active_function];
  wire step_down = accept && !fixed_range && cur_auto && too_low &&
                   (cur_range != `RSMU_RANGE_LOW);
  wire step_up = accept && !fixed_range && cur_auto && too_high &&
                 (cur_range != `RSMU_RANGE_TOP);

  genvar g;
  generate
    for (g = 0; g < `RSMU_NUM_FN; g = g + 1) begin : g_fn
      reg       auto_q;
      reg [2:0] range_q;
      wire sel_cur = (active_function == g);
      assign fn_auto[g] = auto_q;
      assign fn_range[3*g +: 3] = range_q;
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          auto_q  <= 1'b1;
          range_q <= `RSMU_RANGE_TOP;
        end else if (clr_all) begin
          auto_q  <= 1'b1;
          range_q <= `RSMU_RANGE_TOP;
        end else begin
          // commands address the selected function's own entry
          if (cmd_range_manual && sel_cur) begin
            auto_q  <= 1'b0;
            range_q <= (range_value > `RSMU_RANGE_TOP) ?
                       `RSMU_RANGE_TOP : range_value;
          end else if (cmd_range_auto && sel_cur) begin
            auto_q <= range_auto_on;
          end else if (sel_cur && step_down) begin
            range_q <= range_q - 3'h1;
          end else if (sel_cur && step_up) begin
            range_q <= range_q + 3'h1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // active function and range report
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_function <= `RSMU_FN_DCV;
    end else if (clr_all) begin
      active_function <= `RSMU_FN_DCV;
    end else if (cmd_function && function_code < `RSMU_NUM_FN) begin
      active_function <= function_code;
    end
  end

  always @* begin
    if (is_cont) begin
      active_range = `RSMU_RANGE_CONT;
    end else if (is_diode) begin
      active_range = `RSMU_RANGE_DIODE;
    end else if (is_freq) begin
      active_range = `RSMU_RANGE_LOW;
    end else begin
      active_range = cur_range;
    end
    autorange_active = cur_auto && !fixed_range;
  end

  // ----------------------------------------------------------------
  // result and overload
  // ----------------------------------------------------------------
  // overload on a too-high reading in manual, on the top range, or in diode or continuity
  wire overload = too_high && !is_freq &&
                  (!cur_auto || fixed_range ||
                   cur_range == `RSMU_RANGE_TOP);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_valid            <= 1'b0;
      result                  <= 32'sh00000000;
      overload_indication     <= 1'b0;
      remote_word_is_overload <= 32'h00000000;
    end else begin
      result_valid <= accept;
      if (accept) begin
        overload_indication     <= overload;
        remote_word_is_overload <= overload ? `RSMU_OVERLOAD_WORD
                                            : 32'h00000000;
        result <= (is_freq && !signal_present) ? 32'sh00000000
                                               : reading;
      end
    end
  end

  // ----------------------------------------------------------------
  // math selection and state
  // ----------------------------------------------------------------
  function allowed;
    input [2:0] op;
    input [3:0] fn;
    begin
      case (op)
        `RSMU_MATH_NULL:   allowed = (fn <= `RSMU_FN_PERIOD);
        `RSMU_MATH_DB,
        `RSMU_MATH_DBM:    allowed = (fn <= `RSMU_FN_ACV);
        `RSMU_MATH_MINMAX,
        `RSMU_MATH_LIMIT:  allowed = (fn != `RSMU_FN_CONT) &&
                                     (fn != `RSMU_FN_DIODE) &&
                                     (fn < `RSMU_NUM_FN);
        default:           allowed = 1'b0;
      endcase
    end
  endfunction

  reg [2:0] next_math_func;
  reg       next_math_active;
  reg       next_conflict;

  always @* begin
    next_math_func   = math_func;
    next_math_active = math_active;
    next_conflict    = 1'b0;
    if (cmd_math_func && math_func_code < `RSMU_MATH_COUNT) begin
      next_math_func = math_func_code;
      if (math_active && !allowed(math_func_code, active_function)) begin
        next_math_active = 1'b0;
        next_conflict    = 1'b1;
      end
    end
    if (cmd_math_state) begin
      // applied only with state on, and only when allowed
      next_math_active = math_state_on &&
                         allowed(next_math_func, active_function);
    end
    // an ignored function code must not cancel math
    if (cmd_function && function_code != active_function &&
        function_code < `RSMU_NUM_FN) begin
      next_math_active = 1'b0;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      math_func         <= `RSMU_MATH_NULL;
      math_active       <= 1'b0;
      settings_conflict <= 1'b0;
    end else if (clr_all) begin
      math_func         <= `RSMU_MATH_NULL;
      math_active       <= 1'b0;
      settings_conflict <= 1'b0;
    end else begin
      math_func         <= next_math_func;
      math_active       <= next_math_active;
      settings_conflict <= next_conflict;
    end
  end

  // ----------------------------------------------------------------
  // min-max accumulator
  // ----------------------------------------------------------------
  wire minmax_on = math_active && (math_func == `RSMU_MATH_MINMAX);
  wire minmax_start = next_math_active && !minmax_on &&
                      (next_math_func == `RSMU_MATH_MINMAX);
  // overloaded readings are kept out of the statistics
  wire take = minmax_on && accept && !overload;
  wire first = (minmax_count == {`RSMU_CNT_W{1'b0}});
  wire signed [`RSMU_SUM_W-1:0] rd_ext =
    {{(`RSMU_SUM_W-32){reading[31]}}, reading};
  reg  signed [`RSMU_SUM_W-1:0] sum;
  reg                           div_start;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      minmax_min   <= 32'sh00000000;
      minmax_max   <= 32'sh00000000;
      minmax_count <= {`RSMU_CNT_W{1'b0}};
      sum          <= {`RSMU_SUM_W{1'b0}};
      new_min      <= 1'b0;
      new_max      <= 1'b0;
      beep         <= 1'b0;
      div_start    <= 1'b0;
    end else begin
      new_min   <= 1'b0;
      new_max   <= 1'b0;
      beep      <= 1'b0;
      div_start <= 1'b0;
      if (clr_all || minmax_start) begin
        minmax_min   <= 32'sh00000000;
        minmax_max   <= 32'sh00000000;
        minmax_count <= {`RSMU_CNT_W{1'b0}};
        sum          <= {`RSMU_SUM_W{1'b0}};
        div_start    <= 1'b1;
      end else if (take) begin
        if (first) begin
          minmax_min <= reading;
          minmax_max <= reading;
          new_min    <= 1'b1;
          new_max    <= 1'b1;
          beep       <= beeper_enable;
        end else begin
          if (reading < minmax_min) begin
            minmax_min <= reading;
            new_min    <= 1'b1;
          end
          if (reading > minmax_max) begin
            minmax_max <= reading;
            new_max    <= 1'b1;
          end
          beep <= beeper_enable &&
                  (reading < minmax_min || reading > minmax_max);
        end
        // count saturates so the average never divides by a wrapped count
        if (minmax_count != {`RSMU_CNT_W{1'b1}}) begin
          minmax_count <= minmax_count + 1'b1;
          sum          <= sum + rd_ext;
          div_start    <= 1'b1;
        end
      end
    end
  end

  wire [31:0] avg_q;

  rsmu_avg_div u_avg_div (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .start    (div_start),
    .sum      (sum),
    .count    (minmax_count),
    .busy     (minmax_avg_busy),
    .done     (),
    .quotient (avg_q)
  );

  assign minmax_avg = (minmax_count == {`RSMU_CNT_W{1'b0}}) ?
                      32'sh00000000 : avg_q;

endmodule
`default_nettype wire

// File: rsmu_top_props.sv
// property checker for the range select and math unit
`timescale 1ns/1ps
`default_nettype none
`include "rsmu_consts.vh"

module rsmu_top_props (
  // clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rst_n,
  input wire logic                   remote_reset,
  // inputs watched
  input wire logic                   reading_valid,
  input wire logic                   menu_open,
  input wire logic                   beeper_enable,
  // outputs watched
  input wire logic [3:0]             active_function,
  input wire logic [2:0]             active_range,
  input wire logic                   autorange_active,
  input wire logic                   reference_autorange,
  input wire logic                   range_is_freq,
  input wire logic [19:0]            freq_range_hz,
  input wire logic [3:0]             diode_source_ma,
  input wire logic                   result_valid,
  input wire logic                   overload_indication,
  input wire logic [31:0]            remote_word_is_overload,
  input wire logic [2:0]             math_func,
  input wire logic                   math_active,
  input wire logic                   settings_conflict,
  input wire logic signed [31:0]     minmax_min,
  input wire logic signed [31:0]     minmax_max,
  input wire logic [`RSMU_CNT_W-1:0] minmax_count,
  input wire logic                   new_min,
  input wire logic                   new_max,
  input wire logic                   beep
);
  wire logic is_cont  = active_function == `RSMU_FN_CONT;
  wire logic is_diode = active_function == `RSMU_FN_DIODE;
  wire logic is_freq  = active_function == `RSMU_FN_FREQ ||
                        active_function == `RSMU_FN_PERIOD;
  wire logic math_ok  =
    (math_func == `RSMU_MATH_NULL) ? (active_function < `RSMU_FN_CONT) :
    (math_func == `RSMU_MATH_DB || math_func == `RSMU_MATH_DBM) ?
    (active_function < `RSMU_FN_DCI) : !(is_cont || is_diode);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_OVL_WORD: assert property (
    remote_word_is_overload ==
    (overload_indication ? `RSMU_OVERLOAD_WORD : 32'h0))
    else $error("overload word does not follow the flag");
  AST_FREQ_RANGE: assert property (
    range_is_freq == is_freq &&
    freq_range_hz == (is_freq ? `RSMU_FREQ_RANGE_HZ : 20'h0))
    else $error("frequency range report wrong");
  AST_FIXED_RANGE: assert property (
    (!is_diode || (active_range == `RSMU_RANGE_DIODE &&
      diode_source_ma == `RSMU_DIODE_SRC_MA)) &&
    (!is_cont || active_range == `RSMU_RANGE_CONT))
    else $error("fixed range not forced");
  AST_RATIO_REF: assert property (
    reference_autorange == (active_function == `RSMU_FN_RATIO))
    else $error("reference autorange wrong");
  AST_MATH_OK: assert property (
    math_active |-> math_ok)
    else $error("math active for a disallowed function");
  AST_CONFLICT: assert property (
    settings_conflict |-> !math_active && $past(math_active))
    else $error("conflict without active math turning off");
  AST_FN_CHANGE: assert property (
    $changed(active_function) |-> !math_active)
    else $error("math survived a function change");
  AST_RESULT_TIME: assert property (
    reading_valid |=> result_valid == !$past(menu_open))
    else $error("result valid does not follow accepted reading");
  AST_MM_ORDER: assert property (
    minmax_count != 0 |-> minmax_min <= minmax_max)
    else $error("minimum above maximum");
  AST_COUNT_STEP: assert property (
    $changed(minmax_count) |->
    minmax_count == 0 || minmax_count == $past(minmax_count) + 1)
    else $error("reading count jumped");
  AST_BEEP: assert property (
    beep == ((new_min || new_max) && $past(beeper_enable)))
    else $error("beep does not match new extreme");
  AST_AUTO_STEP: assert property (
    $past(autorange_active) && autorange_active && !$past(remote_reset) &&
    $stable(active_function) && $changed(active_range) |->
    active_range == $past(active_range) + 3'h1 ||
    active_range + 3'h1 == $past(active_range))
    else $error("autorange moved more than one range");

  COV_FIRST: cover property (new_min && new_max);
  COV_CONFLICT: cover property (settings_conflict);
  COV_OVL: cover property (overload_indication);
endmodule

bind rsmu_top rsmu_top_props u_props (.*);
`default_nettype wire

// File: rsmu_host.sv
// far-side host model: command pulses, readings and panel levels
`timescale 1ns/1ps
`default_nettype none

module rsmu_host (
  // clock
  input  wire logic               ref_clk,
  // commands
  output var  logic               remote_reset,
  output var  logic               cmd_function,
  output var  logic [3:0]         function_code,
  output var  logic               cmd_range_auto,
  output var  logic               range_auto_on,
  output var  logic               cmd_range_manual,
  output var  logic [2:0]         range_value,
  output var  logic               cmd_math_func,
  output var  logic [2:0]         math_func_code,
  output var  logic               cmd_math_state,
  output var  logic               math_state_on,
  // readings and panel
  output var  logic               reading_valid,
  output var  logic signed [31:0] reading,
  output var  logic               signal_present,
  output var  logic               menu_open,
  output var  logic               beeper_enable
);
  // strobes last one cycle, so one drop serves every command
  task automatic drop;
    {remote_reset, cmd_function, cmd_range_auto, cmd_range_manual,
     cmd_math_func, cmd_math_state, reading_valid} = 7'h00;
  endtask

  initial begin
    drop();
    {function_code, range_value, math_func_code} = 10'h000;
    {range_auto_on, math_state_on, reading} = 34'h0;
    {signal_present, menu_open, beeper_enable} = 3'h1;
  end

  // kind 0 function, 1 auto, 2 manual, 3 math op, 4 math state,
  // 5 reading, else remote reset; every data field follows val
  task automatic send(input int kind, input logic [31:0] val);
    @(negedge ref_clk);
    function_code  = val[3:0];
    range_value    = val[2:0];
    math_func_code = val[2:0];
    range_auto_on  = val[0];
    math_state_on  = val[0];
    reading        = val;
    case (kind)
      0: cmd_function = 1'b1;
      1: cmd_range_auto = 1'b1;
      2: cmd_range_manual = 1'b1;
      3: cmd_math_func = 1'b1;
      4: cmd_math_state = 1'b1;
      5: reading_valid = 1'b1;
      default: remote_reset = 1'b1;
    endcase
    @(negedge ref_clk);
    drop();
  endtask

  // operation first, then the state; in the reverse order the state is judged against the previous operation
  task automatic math_on(input logic [2:0] op);
    send(3, {29'h0, op});
    send(4, 32'h1);
  endtask
endmodule
`default_nettype wire

// File: tb.sv
// self-checking testbench for the range select and math unit
`timescale 1ns/1ps
`default_nettype none
`include "rsmu_consts.vh"

module tb;
  localparam int FN = 0, RA = 1, RM = 2, MF = 3, MS = 4, RD = 5, RR = 6;
  logic ref_clk;
  logic rst_n;
  int   err_total;
  int   comparisons;
  int   f;
  int   o;
  int   n;
  wire logic remote_reset, cmd_function, cmd_range_auto, range_auto_on;
  wire logic cmd_range_manual, cmd_math_func, cmd_math_state, math_state_on;
  wire logic reading_valid, signal_present, menu_open, beeper_enable;
  wire logic [3:0] function_code, active_function, diode_source_ma;
  wire logic [2:0] range_value, math_func_code, active_range, math_func;
  wire logic signed [31:0] reading, result, minmax_min, minmax_max;
  wire logic signed [31:0] minmax_avg;
  wire logic autorange_active, reference_autorange, range_is_freq;
  wire logic result_valid, overload_indication, math_active, beep;
  wire logic settings_conflict, minmax_avg_busy, new_min, new_max;
  wire logic [19:0] freq_range_hz;
  wire logic [31:0] remote_word_is_overload;
  wire logic [`RSMU_CNT_W-1:0] minmax_count;

  rsmu_top  uut  (.*);
  rsmu_host host (.*);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic ok(input int fn, input int op);
    case (op)
      0: ok = fn < 8;
      1, 2: ok = fn < 2;
      default: ok = fn != 8 && fn != 9;
    endcase
  endfunction

  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tdone(input string name);
    $display("Test %s done, %0d mismatches so far", name, err_total);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // stimulus
  // --------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    chk(active_function, `RSMU_FN_DCV);
    chk({autorange_active, active_range}, 4'hC);
    chk({math_active, math_func}, 4'h0);
    chk(minmax_count, 0);
    tdone("reset");
    host.send(RD, 32'h0000C350);
    chk(active_range, 3'h3);
    chk({result_valid, result}, 33'h10000C350);
    host.send(RD, `RSMU_DOWN_LIMIT);
    chk(active_range, 3'h3);
    host.send(RD, `RSMU_UP_LIMIT);
    chk(active_range, 3'h3);
    host.send(RD, 32'h0013D620);
    chk({active_range, overload_indication}, 4'h8);
    host.send(RD, 32'h0013D620);
    chk(overload_indication, 1'b1);
    chk(remote_word_is_overload, `RSMU_OVERLOAD_WORD);
    tdone("autorange");
    host.send(RM, 32'h2);
    host.send(RD, 32'h0000C350);
    chk({autorange_active, active_range}, 4'h2);
    host.send(FN, `RSMU_FN_ACV);
    chk({autorange_active, active_range}, 4'hC);
    host.send(FN, `RSMU_FN_DCV);
    chk({autorange_active, active_range}, 4'h2);
    host.send(RD, 32'h0013D620);
    chk(overload_indication, 1'b1);
    host.send(RA, 32'h1);
    chk(autorange_active, 1'b1);
    tdone("per function range");
    host.send(FN, `RSMU_FN_FREQ);
    chk(range_is_freq, 1'b1);
    chk(freq_range_hz, `RSMU_FREQ_RANGE_HZ);
    host.send(RD, 32'h00001234);
    chk(result, 32'h0);
    host.signal_present = 1'b1;
    host.send(RD, 32'h00001234);
    chk(result, 32'h00001234);
    host.send(FN, `RSMU_FN_DIODE);
    host.send(RM, 32'h3);
    chk(active_range, `RSMU_RANGE_DIODE);
    chk(diode_source_ma, `RSMU_DIODE_SRC_MA);
    host.send(FN, `RSMU_FN_CONT);
    chk(active_range, `RSMU_RANGE_CONT);
    host.send(FN, `RSMU_FN_RATIO);
    chk(reference_autorange, 1'b1);
    tdone("fixed ranges");
    for (f = 0; f < `RSMU_NUM_FN; f++) begin
      for (o = 0; o < `RSMU_MATH_COUNT; o++) begin
        host.send(FN, f);
        host.send(MF, o);
        chk(math_active, 1'b0);
        host.send(MS, 32'h1);
        chk(math_active, ok(f, o));
        if (ok(f, o)) chk(math_func, o);
        host.send(MS, 32'h0);
      end
    end
    host.send(FN, `RSMU_FN_FREQ);
    host.math_on(`RSMU_MATH_NULL);
    host.send(MF, `RSMU_MATH_DB);
    chk({settings_conflict, math_active}, 2'h2);
    host.math_on(`RSMU_MATH_MINMAX);
    host.send(FN, `RSMU_FN_PERIOD);
    chk(math_active, 1'b0);
    tdone("math selection");
    host.send(FN, `RSMU_FN_DCV);
    host.math_on(`RSMU_MATH_MINMAX);
    chk(minmax_count, 0);
    host.send(RD, 32'h0007A120);
    chk({minmax_min, minmax_max}, 64'h0007A1200007A120);
    chk({new_min, new_max, beep}, 3'h7);
    host.send(RD, 32'h000493E0);
    chk({minmax_min, minmax_max}, 64'h000493E00007A120);
    chk({new_min, new_max, beep}, 3'h5);
    host.beeper_enable = 1'b0;
    host.send(RD, 32'h000AAE60);
    chk(minmax_max, 32'h000AAE60);
    chk({new_min, new_max, beep}, 3'h2);
    host.menu_open = 1'b1;
    host.send(RD, 32'h00000064);
    chk({result_valid, minmax_count}, 3);
    chk(math_active, 1'b1);
    host.menu_open = 1'b0;
    repeat (2) @(negedge ref_clk);
    n = 0;
    while (minmax_avg_busy !== 1'b0 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n < 200, 1'b1);
    chk(minmax_avg, 32'h0007A120);
    host.send(MS, 32'h0);
    host.send(MS, 32'h1);
    chk({minmax_min, minmax_max, minmax_count}, 0);
    host.send(RD, 32'h00000014);
    chk(minmax_count, 1);
    host.send(RM, 32'h1);
    host.send(RR, 32'h1);
    chk({minmax_count, math_active}, 0);
    chk(autorange_active, 1'b1);
    tdone("min-max");
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    $display("Error at %0t: run did not finish", $time);
    end_sim();
  end
endmodule
`default_nettype wire
